// file: hdl/lcw_buf.sv
// Two-entry valid/ready buffer between serial capture and display stage
`timescale 1ns/10ps
module lcw_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } lcw_buf_st_t;

  lcw_buf_st_t r_reg;
  lcw_buf_st_t r_next;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------
  // Handshake terms, honest full and empty
  // ----------------------------------------------------------------
  assign in_ready  = (r_reg.cnt != CW'(DEPTH));
  assign out_valid = (r_reg.cnt != '0);
  assign out_data  = r_reg.mem[r_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap kept general so depth can grow
  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = (r_reg.wp == PW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A stalled head word must neither vanish nor change under the reader
  a_buf_stall_hold: assert property (
    @(posedge clk) disable iff (rst)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("buffered word lost or changed during stall");

endmodule

// file: hdl/lcw_top.sv
// Serial-to-parallel character display writer, device side
`timescale 1ns/10ps
module lcw_top (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  input  wire logic       spi_ss_n,
  input  wire logic       lcd_freeze,
  input  wire logic       overrun_clr,
  output logic [7:0]      lcd_data_lines,
  output logic            reg_select_bit,
  output logic            lcd_enable,
  output logic            lcd_rw,
  output logic            second_panel_strobe,
  output logic            link_ready,
  output logic            overrun_flag
);

  typedef struct packed {
    logic                 sck_m;
    logic                 sck_s;
    logic                 sck_d;
    logic                 mosi_m;
    logic                 mosi_s;
    logic                 ss_m;
    logic                 ss_s;
    logic [7:0]           sh;
    logic [2:0]           bitcnt;
    logic                 byte_vld;
    logic [7:0]           byte_dat;
    lcw_pkg::lcw_state_t  state;
    logic [7:0]           hold;
    logic [7:0]           lcd_data;
    logic                 rs;
    logic                 en;
    logic                 en2;
    logic                 rw;
    logic                 link_rdy;
    logic                 ovr;
  } lcw_top_st_t;

  lcw_top_st_t r_reg;
  lcw_top_st_t r_next;
  logic        sck_rise;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [7:0]  buf_dat;
  logic        pop_rdy;
  logic        pop;

  // ----------------------------------------------------------------
  // Link edge detection on synchronised copies only
  // ----------------------------------------------------------------
  // Mode 0 framing: data sampled on rising clock while selected
  assign sck_rise = r_reg.sck_s && !r_reg.sck_d && !r_reg.ss_s;
  // Display stage can take a word only when idle and not frozen
  assign pop_rdy  = (r_reg.state == lcw_pkg::LCW_IDLE) && !lcd_freeze;
  assign pop      = pop_rdy && buf_out_valid;

  // ----------------------------------------------------------------
  // Buffer absorbs a word while the display stage is holding
  // ----------------------------------------------------------------
  lcw_buf #(
    .W     (lcw_pkg::SPI_BITS),
    .DEPTH (lcw_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_valid  (r_reg.byte_vld),
    .in_ready  (buf_in_ready),
    .in_data   (r_reg.byte_dat),
    .out_valid (buf_out_valid),
    .out_ready (pop_rdy),
    .out_data  (buf_dat)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // Two-stage synchronisers; stage one feeds stage two only
    r_next.sck_m  = spi_sck;
    r_next.sck_s  = r_reg.sck_m;
    r_next.sck_d  = r_reg.sck_s;
    r_next.mosi_m = spi_mosi;
    r_next.mosi_s = r_reg.mosi_m;
    r_next.ss_m   = spi_ss_n;
    r_next.ss_s   = r_reg.ss_m;
    r_next.byte_vld = 1'b0;

    // Shift register, MSB first; deselect drops a partial byte
    if (r_reg.ss_s) begin
      r_next.bitcnt = lcw_pkg::RST_BITS;
    end else if (sck_rise) begin
      r_next.sh     = {r_reg.sh[6:0], r_reg.mosi_s};
      r_next.bitcnt = r_reg.bitcnt + 1'b1;
      if (r_reg.bitcnt == 3'h7) begin
        // Every whole byte is offered, no gating by content
        r_next.byte_vld = 1'b1;
        r_next.byte_dat = {r_reg.sh[6:0], r_reg.mosi_s};
      end
    end

    // Lost byte is sticky; a new loss beats a same-cycle clear
    if (r_reg.byte_vld && !buf_in_ready) begin
      r_next.ovr = 1'b1;
    end else if (overrun_clr) begin
      r_next.ovr = 1'b0;
    end
    r_next.link_rdy = buf_in_ready;
    r_next.rw = 1'b0;

    // Display stage: present a byte, then hold it stable
    unique case (r_reg.state)
      lcw_pkg::LCW_IDLE: begin
        if (pop) begin
          r_next.lcd_data = {buf_dat[lcw_pkg::NIB_MSB:0], 4'h0};
          r_next.rs    = buf_dat[lcw_pkg::RS_BIT];
          r_next.en    = buf_dat[lcw_pkg::EN_BIT];
          r_next.en2   = buf_dat[lcw_pkg::EN2_BIT];
          r_next.hold  = 8'(lcw_pkg::HOLD_CYC - 1);
          r_next.state = lcw_pkg::LCW_HOLD;
        end
      end
      lcw_pkg::LCW_HOLD: begin
        // Slow display needs each value to stand a minimum time
        if (r_reg.hold == 8'h00) begin
          r_next.state = lcw_pkg::LCW_IDLE;
        end else begin
          r_next.hold = r_reg.hold - 1'b1;
        end
      end
      default: begin
        r_next.state = lcw_pkg::LCW_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg       <= '0;
      r_reg.ss_m  <= lcw_pkg::RST_SS;
      r_reg.ss_s  <= lcw_pkg::RST_SS;
      r_reg.state <= lcw_pkg::LCW_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  assign lcd_data_lines      = r_reg.lcd_data;
  assign reg_select_bit      = r_reg.rs;
  assign lcd_enable          = r_reg.en;
  assign lcd_rw              = r_reg.rw;
  assign second_panel_strobe = r_reg.en2;
  assign link_ready          = r_reg.link_rdy;
  assign overrun_flag        = r_reg.ovr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_last_bit;
    sck_rise && (r_reg.bitcnt == 3'h7);
  endsequence

  sequence s_byte_out;
    r_reg.byte_vld;
  endsequence

  a_byte_assembled: assert property (
    s_last_bit |=> s_byte_out
      ##0 (r_reg.byte_dat == $past({r_reg.sh[6:0], r_reg.mosi_s})))
    else $error("completed byte not presented");

  a_nibble_upper: assert property (
    pop |=> lcd_data_lines[7:4] == $past(buf_dat[3:0]))
    else $error("nibble not on upper data lines");

  a_select_follows: assert property (
    pop |=> reg_select_bit == $past(buf_dat[lcw_pkg::RS_BIT]))
    else $error("register select mismatch");

  a_enable_hold: assert property (
    pop |=> (lcd_enable == $past(buf_dat[lcw_pkg::EN_BIT]))
      ##1 $stable(lcd_enable)[*8])
    else $error("enable wrong or not held");

  a_low_lines_zero: assert property (
    lcd_data_lines[3:0] == 4'h0)
    else $error("lower data lines driven");

  a_rw_low: assert property (
    !lcd_rw)
    else $error("read/write line not low");

  a_second_enable: assert property (
    pop |=> second_panel_strobe == $past(buf_dat[lcw_pkg::EN2_BIT]))
    else $error("second panel enable mismatch");

  a_byte_reaches: assert property (
    (r_reg.byte_vld && buf_in_ready) |=> buf_out_valid)
    else $error("accepted byte missing from buffer");

  a_loss_flagged: assert property (
    (r_reg.byte_vld && !buf_in_ready) |=> overrun_flag)
    else $error("lost byte not flagged");

  // Clear only wins when no loss lands in the same cycle
  a_overrun_clear: assert property (
    (overrun_clr && !(r_reg.byte_vld && !buf_in_ready)) |=> !overrun_flag)
    else $error("overrun flag not cleared");

  // Deselect must discard a partial byte before the next frame
  a_partial_drop: assert property (
    r_reg.ss_s |=> (r_reg.bitcnt == lcw_pkg::RST_BITS))
    else $error("bit count kept across deselect");

endmodule

// file: shared/lcw_pkg.sv
// Constants and types shared by the serial character display writer
// Contract
// - Serial bytes from the host port appear in parallel on the display pins.
// - Display runs in 4-bit bus mode, panels up to 80 characters.
// - Select low marks a command, select high marks character data.
// - Display enable is active high and follows transfer bit D7.
// - Only upper four data lines carry the nibble; lower four stay low.
// - Read/write line is held low, so every strobe is a write.
// - A second active-high enable drives the second panel half.
// - No isolation: every completed transfer is offered; one arriving with the buffer full is lost and sets the overrun flag.
package lcw_pkg;

  // ----------------------------------------------------------------
  // Transfer byte layout
  // ----------------------------------------------------------------
  localparam int SPI_BITS = 8;
  localparam int EN_BIT   = 7;   // Display enable strobe
  localparam int RS_BIT   = 6;   // Register select
  localparam int EN2_BIT  = 5;   // Second panel half enable
  localparam int NIB_MSB  = 3;   // Nibble in bits 3..0
  localparam int LCD_W    = 8;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Timing: least time each presented value stands on the pins
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 20;
  localparam int LCD_HOLD_NS = 500;
  localparam int HOLD_CYC    = (LCD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W      = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_BITS  = 3'h0;
  localparam logic       RST_SS    = 1'b1;

  // ----------------------------------------------------------------
  // Output stage states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LCW_IDLE = 2'b01,
    LCW_HOLD = 2'b10
  } lcw_state_t;

endpackage

// file: verif/lcw_host_model.sv
// Host serial master model driving the display writer's link
`timescale 1ns/10ps
module lcw_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      mosi,
  output logic      ss_n
);
  // Core cycles per half link period: 4 x 50 ns gives 200 ns
  localparam int HALF = 4;

  // Idle link: clock still, select high, data parked high
  initial begin
    sck  = 1'b0;
    mosi = 1'b1;
    ss_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Mode 0 transfer, MSB first; a short count leaves a partial byte
  // ----------------------------------------------------------------
  // No read path at all: the display is treated as write-only
  task automatic xfer(input logic [7:0] b, input int nbits);
    int i;
    @(posedge clk);
    ss_n <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      mosi <= b[7 - i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    ss_n <= 1'b1;
    // Released line flips so a stale bit is never mistaken for data
    mosi <= ~mosi;
  endtask
endmodule

// file: verif/tb_lcw_top.sv
// Self-checking bench for the serial character display writer
`timescale 1ns/10ps
module tb_lcw_top;
  logic        core_clk    = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        lcd_freeze  = 1'b0;
  logic        overrun_clr = 1'b0;
  logic        spi_sck;
  logic        spi_mosi;
  logic        spi_ss_n;
  logic [7:0]  lcd_data_lines;
  logic        reg_select_bit;
  logic        lcd_enable;
  logic        lcd_rw;
  logic        second_panel_strobe;
  logic        link_ready;
  logic        overrun_flag;
  logic [11:0] pins;
  logic [7:0]  b0;
  logic [7:0]  b1;
  int          error_cnt   = 0;
  int          compares    = 0;
  int          seed        = 32'h6c3b;

  // 50 ns clock
  always #25 core_clk = ~core_clk;

  // All display-side outputs in one vector for comparison
  assign pins = {lcd_data_lines, reg_select_bit, lcd_enable,
                 second_panel_strobe, lcd_rw};

  lcw_top dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n), .lcd_freeze(lcd_freeze),
    .overrun_clr(overrun_clr), .lcd_data_lines(lcd_data_lines),
    .reg_select_bit(reg_select_bit), .lcd_enable(lcd_enable),
    .lcd_rw(lcd_rw), .second_panel_strobe(second_panel_strobe),
    .link_ready(link_ready), .overrun_flag(overrun_flag)
  );

  lcw_host_model host (
    .clk(core_clk), .sck(spi_sck), .mosi(spi_mosi), .ss_n(spi_ss_n)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Nibble high, low lines zero, select, enable, second enable, rw low
  function automatic logic [11:0] exp_pins(input logic [7:0] b);
    return {b[3:0], 4'h0, b[6], b[7], b[5], 1'b0};
  endfunction

  // Bounded wait for a transfer to show; a hang ends the run
  task automatic wait_pins(input logic [7:0] b);
    int n;
    n = 0;
    while (pins !== exp_pins(b) && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk("display pins", exp_pins(b), pins);
    // Only a real timeout ends the run early; the mismatch is counted
    if (pins !== exp_pins(b)) begin
      conclude();
    end
  endtask

  // Three transfers per nibble, enable low, high, low
  task automatic put_nib(input logic [3:0] nib, input logic rs,
                         input logic en2);
    logic [7:0] b;
    b = {1'b0, rs, en2, 1'b0, nib};
    host.xfer(b, 8);
    wait_pins(b);
    host.xfer(b | 8'h80, 8);
    wait_pins(b | 8'h80);
    host.xfer(b, 8);
    wait_pins(b);
  endtask

  // Upper nibble first; commands followed by their settle time
  task automatic put_byte(input logic [7:0] c, input logic rs,
                          input logic en2);
    put_nib(c[7:4], rs, en2);
    put_nib(c[3:0], rs, en2);
    if (!rs) begin
      repeat ((c <= 8'h02) ? 33000 : 800) @(posedge core_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("reset pins", 12'h000, pins);
    chk("reset ready", 12'h001, link_ready);
    chk("reset overrun", 12'h000, overrun_flag);
    // Fixed command codes, then a random address and characters
    put_byte(8'h3C, 1'b0, 1'b0);
    put_byte(8'h01, 1'b0, 1'b0);
    b0 = $random(seed);
    put_byte(8'h80 | b0, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) begin
      b0 = $random(seed);
      put_byte({1'b0, b0[6:0]} | 8'h20, 1'b1, b0[7]);
    end
    // A partial byte cut by deselect must leave no trace
    host.xfer(8'hFF, 3);
    put_nib(4'hA, 1'b1, 1'b0);
    // Frozen display: two bytes buffered, the third lost
    @(posedge core_clk);
    lcd_freeze <= 1'b1;
    b0 = $random(seed);
    b0[7] = 1'b0;
    b1 = b0 ^ 8'hCF;
    host.xfer(b0, 8);
    host.xfer(b1, 8);
    host.xfer(~b0, 8);
    repeat (4) @(negedge core_clk);
    chk("full ready", 12'h000, link_ready);
    chk("overrun set", 12'h001, overrun_flag);
    @(posedge core_clk);
    lcd_freeze <= 1'b0;
    wait_pins(b0);
    wait_pins(b1);
    @(posedge core_clk);
    overrun_clr <= 1'b1;
    @(posedge core_clk);
    overrun_clr <= 1'b0;
    repeat (20) @(negedge core_clk);
    chk("overrun clear", 12'h000, overrun_flag);
    chk("drained ready", 12'h001, link_ready);
    conclude();
  end
endmodule
